// File: rtl/dfpec_cfg.svh
`ifndef DFPEC_CFG_SVH
`define DFPEC_CFG_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DFPEC_IDX_STATUS      10'h000
`define DFPEC_IDX_WORD_INDEX  10'h001
`define DFPEC_IDX_BUFFER      10'h002
`define DFPEC_IDX_CONTROL     10'h003
`define DFPEC_IDX_EEE_START   10'h004
`define DFPEC_IDX_ERR_STATUS  10'h007
`define DFPEC_IDX_IRQ_STATUS  10'h008
`define DFPEC_IDX_IRQ_MASK    10'h009

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DFPEC_ST_COMMAND_COMPLETE_FLAG         7
`define DFPEC_ST_ACCESS_ERROR_FLAG       5
`define DFPEC_ST_PROTECTION_VIOLATION_FLAG       4
`define DFPEC_ST_BUSY         3
`define DFPEC_ST_VERR         1
`define DFPEC_ST_VUNC         0
`define DFPEC_CTL_LOADING     0
`define DFPEC_CTL_MODE_OK     1
`define DFPEC_ERR_EPVIOL      4
`define DFPEC_ERR_DOUBLE      1
`define DFPEC_ERR_SINGLE      0
`define DFPEC_IRQ_DONE        0
`define DFPEC_IRQ_ACCESS_ERROR_FLAG      1
`define DFPEC_IRQ_VERIFY      2

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define DFPEC_RST_CONTROL     8'h02
`define DFPEC_RST_EEE_START   16'h8000
`define DFPEC_CMD_PROGRAM     8'h11
`define DFPEC_CMD_ERASE       8'h12
`define DFPEC_IDX_MIN_PROG    3'h2
`define DFPEC_IDX_MAX_PROG    3'h5
`define DFPEC_IDX_ERASE       3'h1
`define DFPEC_DF_BASE         23'h10_0000
`define DFPEC_ERASED_WORD     16'hFFFF

`endif

// File: rtl/dfpec_pkg.sv
package dfpec_pkg;

    // operation handed to the array engine
    typedef struct packed {
        logic        erase;
        logic [22:0] addr;
        logic [7:0]  words;
        logic [63:0] data;
    } dfpec_cmd_t;

    // request to the flash array
    typedef struct packed {
        logic        req;
        logic        write;
        logic [22:0] addr;
        logic [15:0] wdata;
    } dfpec_arr_req_t;

    // answer from the flash array
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
        logic        err;
        logic        uncorr;
    } dfpec_arr_rsp_t;

    typedef enum logic [3:0] {
        E_IDLE   = 4'b0001,
        E_WRITE  = 4'b0010,
        E_VERIFY = 4'b0100,
        E_DONE   = 4'b1000
    } dfpec_eng_state_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_CHECK = 3'b010,
        S_RUN   = 3'b100
    } dfpec_seq_state_t;

endpackage

// File: rtl/dfpec_engine.sv
`timescale 1ns/1ps
`include "dfpec_cfg.svh"

module dfpec_engine (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // command from the sequencer
    input  wire logic                    start,
    input  wire dfpec_pkg::dfpec_cmd_t   cmd,
    output logic                         done,
    output logic                         verify_err,
    output logic                         verify_unc,
    // flash array port
    output dfpec_pkg::dfpec_arr_req_t    arr_req,
    input  wire dfpec_pkg::dfpec_arr_rsp_t arr_rsp
);
    import dfpec_pkg::*;

    dfpec_eng_state_t state;
    dfpec_cmd_t       op;
    logic [7:0]       pos;
    logic [15:0]      expect_word;
    logic [1:0]       sel;

    // ---------------------------------------------------------------
    // word expected at the current position
    // ---------------------------------------------------------------
    assign sel = pos[1:0];
    assign expect_word = op.erase ? `DFPEC_ERASED_WORD : op.data[16*sel +: 16];

    // request to the array, one word at a time
    assign arr_req.req   = (state == E_WRITE) || (state == E_VERIFY);
    assign arr_req.write = (state == E_WRITE);
    assign arr_req.addr  = op.addr + {14'h0000, pos, 1'b0};
    assign arr_req.wdata = expect_word;

    // ---------------------------------------------------------------
    // walk: write every word, then read every word back
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= E_IDLE;
            op    <= '0;
            pos   <= 8'h00;
        end else begin
            case (state)
                E_IDLE: begin
                    if (start) begin
                        op    <= cmd;
                        pos   <= 8'h00;
                        state <= E_WRITE;
                    end
                end
                E_WRITE: begin
                    if (arr_rsp.ack) begin
                        if (pos == op.words - 8'h01) begin
                            pos   <= 8'h00;
                            state <= E_VERIFY; // erase then verify [RL13]
                        end else begin
                            pos <= pos + 8'h01;
                        end
                    end
                end
                E_VERIFY: begin
                    if (arr_rsp.ack) begin
                        if (pos == op.words - 8'h01) begin
                            state <= E_DONE;
                        end else begin
                            pos <= pos + 8'h01;
                        end
                    end
                end
                E_DONE: begin
                    state <= E_IDLE;
                end
                default: begin
                    state <= E_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // verify result collection
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            verify_err <= 1'b0;
            verify_unc <= 1'b0;
        end else if (state == E_IDLE && start) begin
            verify_err <= 1'b0;
            verify_unc <= 1'b0;
        end else if (state == E_VERIFY && arr_rsp.ack) begin
            if (arr_rsp.err || arr_rsp.uncorr || arr_rsp.rdata != expect_word) begin
                verify_err <= 1'b1; // any verify fault [RL8]
            end
            if (arr_rsp.uncorr) begin
                verify_unc <= 1'b1; // uncorrectable fault [RL9]
            end
        end
    end

    assign done = (state == E_DONE);

endmodule

// File: rtl/dfpec_top.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "dfpec_cfg.svh"

// Functional notes
// (RL1) program: index must lie 010 to 101
// (RL2) program during field loading: access error
// (RL3) command barred in mode: access error
// (RL4) invalid global address: access error
// (RL5) odd word address: access error; only program checks it here, erase is not refused for an odd address
// (RL6) program into eeprom partition: access error
// (RL7) words breaching block or partition: access error
// (RL8) any verify fault sets upper status bit
// (RL9) uncorrectable verify fault sets lower bit
// (RL10) error status readable, writes only clear
// (RL11) erase word 000: code 0x12, address high
// (RL12) erase word 001: address low in sector
// (RL13) erase whole sector, then verify it
// (RL14) complete flag returns after erase verify
// (RL15) write one to complete flag launches command
// (RL16) launch ignored while access error set
// (RL17) access error cleared by writing one
// (RL18) rejected command leaves array untouched

module dfpec_top #(
    parameter logic [22:0] DF_SIZE     = 23'h00_8000,
    parameter int          SECT_BYTES  = 256
) (
    // ahb-lite clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // flash array
    output dfpec_pkg::dfpec_arr_req_t      arr_req,
    input  wire dfpec_pkg::dfpec_arr_rsp_t arr_rsp,
    // interrupt
    output logic                           irq
);
    import dfpec_pkg::*;

    localparam logic [7:0] SECT_WORDS = 8'(SECT_BYTES / 2);
    localparam logic [22:0] SECT_MASK = 23'(SECT_BYTES - 1);

    // register state
    logic        command_complete_flag, access_error_flag, protection_violation_flag, verr, vunc;
    logic [2:0]  word_index;
    logic [15:0] cmd_buf [0:5];
    logic [7:0]  control;
    logic [15:0] eee_start;
    logic [7:0]  err_status;
    logic [2:0]  irq_status, irq_mask;

    // bus phase capture
    logic        wr_data_phase, rd_pend;
    logic [9:0]  ph_index;

    // sequencer
    dfpec_seq_state_t seq;
    logic        launch, reject, eng_start;
    logic        eng_done, eng_verr, eng_vunc;
    dfpec_cmd_t  cmd;

    // --------------------
    // ahb-lite address phase capture
    // --------------------
    logic addr_ok;
    assign addr_ok = hsel && hready && htrans[1];

    // writes need no wait, reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_data_phase <= 1'b0;
            rd_pend  <= 1'b0;
            ph_index <= 10'h000;
        end else begin
            wr_data_phase <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok) begin
                ph_index <= haddr[11:2];
            end
        end
    end

    // read data is sampled in the wait cycle of a read
    logic rd_wait;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
        end else begin
            rd_wait <= rd_pend && !rd_wait;
        end
    end

    assign hreadyout = !(rd_pend && !rd_wait);
    assign hresp     = 1'b0;

    // write strobes per register
    logic wr_status, wr_err, wr_irq;
    assign wr_status = wr_data_phase && ph_index == `DFPEC_IDX_STATUS;
    assign wr_err    = wr_data_phase && ph_index == `DFPEC_IDX_ERR_STATUS;
    assign wr_irq    = wr_data_phase && ph_index == `DFPEC_IDX_IRQ_STATUS;

    // --------------------
    // read mux
    // --------------------
    logic [7:0] status_view;
    assign status_view = {command_complete_flag, 1'b0, access_error_flag, protection_violation_flag, !command_complete_flag, 1'b0, verr, vunc};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend && !rd_wait) begin
            case (ph_index)
                `DFPEC_IDX_STATUS:     hrdata <= {24'h00_0000, status_view};
                `DFPEC_IDX_WORD_INDEX: hrdata <= {29'h0000_0000, word_index};
                `DFPEC_IDX_BUFFER:     hrdata <= {16'h0000, (word_index <= 3'h5) ?
                                                  cmd_buf[word_index] : 16'h0000};
                `DFPEC_IDX_CONTROL:    hrdata <= {24'h00_0000, control};
                `DFPEC_IDX_EEE_START:  hrdata <= {16'h0000, eee_start};
                `DFPEC_IDX_ERR_STATUS: hrdata <= {24'h00_0000, err_status}; // [RL10]
                `DFPEC_IDX_IRQ_STATUS: hrdata <= {29'h0000_0000, irq_status};
                `DFPEC_IDX_IRQ_MASK:   hrdata <= {29'h0000_0000, irq_mask};
                default:               hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------
    // plain configuration registers
    // --------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_index <= 3'h0;
            control    <= `DFPEC_RST_CONTROL;
            eee_start  <= `DFPEC_RST_EEE_START;
            irq_mask   <= 3'h0;
        end else if (wr_data_phase) begin
            case (ph_index)
                `DFPEC_IDX_WORD_INDEX: word_index <= hwdata[2:0];
                `DFPEC_IDX_CONTROL:    control    <= hwdata[7:0];
                `DFPEC_IDX_EEE_START:  eee_start  <= hwdata[15:0];
                `DFPEC_IDX_IRQ_MASK:   irq_mask   <= hwdata[2:0];
                default:               word_index <= word_index;
            endcase
        end
    end

    // command buffer, one word per index
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 6; i++) begin
                cmd_buf[i] <= 16'h0000;
            end
        end else if (wr_data_phase && ph_index == `DFPEC_IDX_BUFFER
                     && word_index <= 3'h5 && command_complete_flag) begin
            cmd_buf[word_index] <= hwdata[15:0]; // words 000 and 001 [RL11] [RL12]
        end
    end

    // --------------------
    // launch checks
    // --------------------
    logic [7:0]  code;
    logic [22:0] gaddr;
    logic [22:0] off;
    logic [22:0] last;
    logic [7:0]  nwords;
    logic        is_prog, is_erase, in_range, bad;

    assign code     = cmd_buf[0][15:8];
    assign gaddr    = {cmd_buf[0][6:0], cmd_buf[1]};
    assign off      = gaddr - `DFPEC_DF_BASE;
    assign is_prog  = code == `DFPEC_CMD_PROGRAM;
    assign is_erase = code == `DFPEC_CMD_ERASE;
    assign nwords   = {5'h00, word_index} - 8'h01;
    assign last     = off + {14'h0000, nwords, 1'b0} - 23'h00_0002;
    assign in_range = gaddr >= `DFPEC_DF_BASE && off < DF_SIZE;

    always_comb begin
        bad = 1'b0;
        if (!is_prog && !is_erase) bad = 1'b1;
        if (!control[`DFPEC_CTL_MODE_OK]) bad = 1'b1; // not allowed in this mode [RL3]
        if (!in_range) bad = 1'b1; // no such location [RL4]
        if (is_erase && word_index != `DFPEC_IDX_ERASE) bad = 1'b1;
        if (is_erase && in_range && off >= {7'h00, eee_start}) begin
            bad = 1'b1; // erase limited to the user partition [RL13]
        end
        if (is_prog) begin
            if (word_index < `DFPEC_IDX_MIN_PROG || word_index > `DFPEC_IDX_MAX_PROG) begin
                bad = 1'b1; // index window [RL1]
            end
            if (control[`DFPEC_CTL_LOADING]) bad = 1'b1; // field load still running [RL2]
            if (gaddr[0]) bad = 1'b1; // misaligned word [RL5]
            if (off >= {7'h00, eee_start}) bad = 1'b1; // start in eeprom region [RL6]
            if (last >= DF_SIZE || last >= {7'h00, eee_start}) begin
                bad = 1'b1; // run breaches the end [RL7]
            end
        end
    end

    // operation given to the engine
    always_comb begin
        cmd.erase = is_erase;
        cmd.addr  = is_erase ? (gaddr & ~SECT_MASK) : gaddr;
        cmd.words = is_erase ? SECT_WORDS : nwords;
        cmd.data  = {cmd_buf[5], cmd_buf[4], cmd_buf[3], cmd_buf[2]};
    end

    // --------------------
    // sequencer
    // --------------------
    assign launch    = wr_status && hwdata[`DFPEC_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag
                       && !access_error_flag && !protection_violation_flag; // blocked by errors [RL15] [RL16]
    assign reject    = (seq == S_CHECK) && bad;
    assign eng_start = (seq == S_CHECK) && !bad; // array left alone on error [RL18]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq <= S_IDLE;
        end else begin
            case (seq)
                S_IDLE:  if (launch) seq <= S_CHECK;
                S_CHECK: seq <= bad ? S_IDLE : S_RUN;
                S_RUN:   if (eng_done) seq <= S_IDLE;
                default: seq <= S_IDLE;
            endcase
        end
    end

    // complete flag: low from launch to finish or reject
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            command_complete_flag <= 1'b1;
        end else if (launch) begin
            command_complete_flag <= 1'b0; // [RL15]
        end else if (reject || eng_done) begin
            command_complete_flag <= 1'b1; // after a reject, or after the erase or write and its verify [RL14]
        end
    end

    // access error: set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_error_flag <= 1'b0;
        end else if (reject) begin
            access_error_flag <= 1'b1;
        end else if (wr_status && hwdata[`DFPEC_ST_ACCESS_ERROR_FLAG]) begin
            access_error_flag <= 1'b0; // write one clears [RL17]
        end
    end

    // protection violation: nothing here sets it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protection_violation_flag <= 1'b0;
        end else if (wr_status && hwdata[`DFPEC_ST_PROTECTION_VIOLATION_FLAG]) begin
            protection_violation_flag <= 1'b0;
        end
    end

    // verify status, renewed at each launch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            verr <= 1'b0;
            vunc <= 1'b0;
        end else if (launch) begin
            verr <= 1'b0;
            vunc <= 1'b0;
        end else if (eng_done) begin
            verr <= eng_verr; // [RL8]
            vunc <= eng_vunc; // [RL9]
        end
    end

    // error status: hardware sets, software only clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_status <= 8'h00;
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (eng_done && b == `DFPEC_ERR_SINGLE && eng_verr && !eng_vunc) begin
                    err_status[b] <= 1'b1;
                end else if (eng_done && b == `DFPEC_ERR_DOUBLE && eng_vunc) begin
                    err_status[b] <= 1'b1;
                end else if (wr_err && hwdata[b]) begin
                    err_status[b] <= 1'b0; // write can only clear [RL10]
                end
            end
        end
    end

    // --------------------
    // interrupt status and output
    // --------------------
    logic [2:0] irq_set;
    assign irq_set = {eng_done && eng_verr, reject, reject || eng_done};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= irq_set | (irq_status & ~({3{wr_irq}} & hwdata[2:0]));
        end
    end

    assign irq = |(irq_status & irq_mask);

    // --------------------
    // array engine
    // --------------------
    dfpec_engine u_engine (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .start      (eng_start),
        .cmd        (cmd),
        .done       (eng_done),
        .verify_err (eng_verr),
        .verify_unc (eng_vunc),
        .arr_req    (arr_req),
        .arr_rsp    (arr_rsp)
    );

endmodule

// File: sim/dfpec_assertions.sv
`timescale 1ns/1ps
// -------------------------------------------------------------
// port checker for the sequencer top
// -------------------------------------------------------------
module dfpec_checker #(
    parameter logic [22:0] DF_SIZE = 23'h00_8000
) (
    // clock and reset
    input wire logic                      hclk,
    input wire logic                      hresetn,
    // register bus
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [31:0]               hwdata,
    input wire logic                      hready,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    // array and interrupt
    input wire dfpec_pkg::dfpec_arr_req_t arr_req,
    input wire dfpec_pkg::dfpec_arr_rsp_t arr_rsp,
    input wire logic                      irq
);
    import dfpec_pkg::*;
    logic       wr_ph;
    logic [9:0] ph_idx;
    wire        take   = hsel && hready && htrans[1];
    wire        launch = wr_ph && hready && ph_idx == 10'h000 && hwdata[7];
    // follow the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph  <= 1'b0;
            ph_idx <= 10'h000;
        end else if (hready) begin
            wr_ph  <= take && hwrite;
            ph_idx <= haddr[11:2];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence seq_read_phase;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence seq_no_req;
        !arr_req.req ##1 !arr_req.req;
    endsequence
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (take && !hwrite |=> seq_read_phase)
        else $error("read data phase length wrong");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_req_hold: assert property (arr_req.req && !arr_rsp.ack |=> $stable(arr_req))
        else $error("array request changed before ack");
    chk_addr_even: assert property (arr_req.req |-> !arr_req.addr[0])
        else $error("odd array address");
    chk_addr_range: assert property (arr_req.req |-> arr_req.addr >= 23'h10_0000
        && arr_req.addr < 23'h10_0000 + DF_SIZE) else $error("array address out of block");
    chk_launch_gap: assert property (launch && !arr_req.req |-> seq_no_req)
        else $error("array access before check");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && !arr_req.req)
        else $error("outputs busy after reset");
endmodule

bind dfpec_top dfpec_checker #(.DF_SIZE(DF_SIZE)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .arr_req(arr_req), .arr_rsp(arr_rsp), .irq(irq));

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "dfpec_cfg.svh"
module testbench;
    import dfpec_pkg::*;
    logic           hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0]    haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]     htrans = 0;
    logic           hreadyout, hresp, irq, inj_err = 0, inj_unc = 0, go;
    dfpec_arr_req_t arr_req;
    dfpec_arr_rsp_t arr_rsp = '0;
    logic [15:0]    mem [logic [22:0]];
    logic [22:0]    base, a;
    logic [15:0]    dat;
    logic [7:0]     ctl [8] = '{2, 2, 3, 0, 2, 2, 2, 2};
    logic [2:0]     ix [8] = '{1, 6, 2, 2, 2, 2, 2, 5};
    logic [22:0]    ad [8] = '{23'h10_0000, 23'h10_0000, 23'h10_0000, 23'h10_0000,
                               23'h20_0000, 23'h10_0001, 23'h10_4000, 23'h10_3FFC};
    int             bad_count = 0, checks_done = 0, nwr = 0, e;
    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;
    dfpec_top dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .arr_req(arr_req), .arr_rsp(arr_rsp), .irq(irq));
    // array answers with random stalls, storing writes
    always @(posedge hclk) begin
        go = arr_req.req && !arr_rsp.ack && $urandom_range(1);
        arr_rsp.ack <= go;
        arr_rsp.err <= inj_err;
        arr_rsp.uncorr <= inj_unc;
        arr_rsp.rdata <= (go && !arr_req.write) ? mem[arr_req.addr] : ~arr_rsp.rdata;
        if (go && arr_req.write) begin
            mem[arr_req.addr] = arr_req.wdata;
            nwr++;
        end
    end
    function automatic logic [15:0] exp_word(input logic [15:0] d, input int k);
        return d + 16'(k);
    endfunction
    task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, i, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // load buffer words, launch, poll the complete flag
    task automatic run(input logic [7:0] code, input logic [22:0] g, input logic [2:0] n);
        bus(1, `DFPEC_IDX_WORD_INDEX, 0);
        bus(1, `DFPEC_IDX_BUFFER, {16'h0000, code, 1'b0, g[22:16]});
        bus(1, `DFPEC_IDX_WORD_INDEX, 1);
        bus(1, `DFPEC_IDX_BUFFER, {16'h0000, g[15:0]});
        for (int k = 2; k <= n; k++) begin
            bus(1, `DFPEC_IDX_WORD_INDEX, k);
            bus(1, `DFPEC_IDX_BUFFER, {16'h0000, exp_word(dat, k)});
        end
        bus(1, `DFPEC_IDX_WORD_INDEX, {29'h0, n});
        bus(1, `DFPEC_IDX_STATUS, 32'h0000_0080);
        e = 0;
        do begin
            bus(0, `DFPEC_IDX_STATUS, 0);
            e++;
        end while (q[7] !== 1'b1 && e < 300);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    initial begin
        #200_000;
        bad_count++;
        $display("FAIL %0t run timed out", $time);
        conclude;
    end
    initial begin
        void'($urandom(32'h6b76));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `DFPEC_IDX_STATUS, 0);
        chk(q, 32'h0000_0080, "status reset");
        bus(0, `DFPEC_IDX_ERR_STATUS, 0);
        chk(q, 32'h0000_0000, "error status reset");
        $display("test reset done");
        base = 23'h10_0000 + {7'h00, 8'($urandom_range(127)), 8'h00};
        for (int k = 0; k < 128; k++) mem[base + 23'(2 * k)] = 16'h0000;
        nwr = 0;
        run(`DFPEC_CMD_ERASE, base | {15'h0, 7'($urandom_range(127)), 1'b0}, 1);
        chk(q[7], 1'b1, "erase complete");
        chk(nwr, 128, "erase word count");
        e = 0;
        for (int k = 0; k < 128; k++) e += (mem[base + 23'(2 * k)] !== 16'hFFFF);
        chk(e, 0, "sector not erased");
        $display("test erase done");
        dat = 16'($urandom);
        a = 23'h10_0000 + {12'h000, 10'($urandom_range(1000)), 1'b0};
        run(`DFPEC_CMD_PROGRAM, a, 5);
        chk(q[7:0] & 8'hA3, 8'h80, "clean program status");
        for (int k = 0; k < 4; k++) chk(mem[a + 23'(2 * k)], exp_word(dat, k + 2), "data");
        $display("test program done");
        bus(1, `DFPEC_IDX_EEE_START, 32'h0000_4000);
        for (int c = 0; c < 8; c++) begin
            nwr = 0;
            bus(1, `DFPEC_IDX_CONTROL, {24'h0, ctl[c]});
            run(`DFPEC_CMD_PROGRAM, ad[c], ix[c]);
            chk(q[5], 1'b1, "launch not refused");
            chk(nwr, 0, "refused command wrote");
            bus(1, `DFPEC_IDX_CONTROL, 32'h0000_0002);
            if (c < 7) bus(1, `DFPEC_IDX_STATUS, 32'h0000_0020);
        end
        run(`DFPEC_CMD_PROGRAM, 23'h10_0100, 2);
        chk(nwr, 0, "launch taken under access error");
        bus(1, `DFPEC_IDX_STATUS, 32'h0000_0000);
        bus(0, `DFPEC_IDX_STATUS, 0);
        chk(q[5], 1'b1, "zero write cleared flag");
        bus(1, `DFPEC_IDX_STATUS, 32'h0000_0020);
        bus(0, `DFPEC_IDX_STATUS, 0);
        chk(q[5], 1'b0, "one write left flag");
        $display("test refusals done");
        for (int u = 0; u < 2; u++) begin
            inj_err <= 1'b1;
            inj_unc <= u[0];
            run(`DFPEC_CMD_PROGRAM, 23'h10_0200, 2);
            inj_err <= 1'b0;
            chk(q[1:0], {1'b1, u[0]}, "verify status");
            bus(0, `DFPEC_IDX_ERR_STATUS, 0);
            chk(q[1], u[0], "double fault flag");
            bus(1, `DFPEC_IDX_ERR_STATUS, 32'h0000_0000);
            bus(0, `DFPEC_IDX_ERR_STATUS, 0);
            chk(q[1], u[0], "zero write changed flag");
            bus(1, `DFPEC_IDX_ERR_STATUS, 32'h0000_00FF);
            bus(0, `DFPEC_IDX_ERR_STATUS, 0);
            chk(q, 32'h0000_0000, "write set or kept flag");
        end
        $display("test verify done");
        bus(1, `DFPEC_IDX_IRQ_MASK, 32'h0000_0000);
        #1 chk(irq, 1'b0, "masked interrupt high");
        bus(1, `DFPEC_IDX_IRQ_MASK, 32'h0000_0001);
        #1 chk(irq, 1'b1, "done interrupt low");
        bus(1, `DFPEC_IDX_IRQ_STATUS, 32'h0000_0007);
        #1 chk(irq, 1'b0, "cleared interrupt high");
        bus(0, 10'h3FF, 0);
        chk(q, 32'h0000_0000, "unmapped read");
        $display("test interrupt done");
        conclude;
    end
endmodule
